// *** dsc_ctrl.sv ***
// Output-path control of a dual-output clock synthesizer with an AHB-Lite register slave.
// Assumes hclk stands for the master clock and the bench joins the pin enables to wires.
//
// Function
// - Reference prescaler divides master clock by 1, 2, 4 or 8.
// - Main prescaler divides master clock by 1, 2, 4 or 8 into divider.
// - Programmable divider divides by 2 to 1025, ratio from 10-bit value.
// - Bypass bit routes main prescaler output straight to main output.
// - Bypass set ignores divider ratio; clear lets divider run normally.
// - A 10-bit control word sets master frequency in step increments.
// - A range offset selects which band the control word spans.
// - Step, span and offset size are variant parameters.
// - Both outputs derive from master clock with independent settings.
// - Output enable is glitch free with constant delay to first edge.
// - Reference pin role decodes from power-down, enable and select bits.
// - All bits zero: output off, pin high powers down; select: pin picks divide.
// - Enable or power-down bit: pin high turns output off, low drives clock.
// - Main pin is active-low enable; with power-down bit it powers down.
// - Pin power-down requests are ORed, each gated by its own power-down bit or, for the ref pin, by all bits zero.
// - Power-down stops the master oscillator.
// - Settings load nonvolatile defaults at power-up.
// - Host writes all settings on the fly while running.
// - Main frequency is master over twice prescaler times divider, or over twice prescaler when bypassed.
`default_nettype none

`include "dsc_map.svh"

module dsc_ctrl
    import dsc_pkg::*;
#(
    parameter logic [8:0]  MUX_RST    = `DSC_MUX_RST,
    parameter logic [9:0]  DAC_RST    = `DSC_DAC_RST,
    parameter logic [4:0]  OFS_RST    = `DSC_OFS_RST,
    parameter logic [9:0]  DIV_RST    = `DSC_DIV_RST,
    parameter logic [31:0] STEP_KHZ   = 32'd10,
    parameter logic [31:0] OFSZ_KHZ   = 32'd5120,
    parameter logic [31:0] BASE_KHZ   = 32'd92100
) (
    // Clock, reset and freeze.
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Control pins and clock outputs.
    input  wire logic        ref_ctrl_pin,
    input  wire logic        main_ctrl_pin,
    output logic             ref_clk_out,
    output logic             ref_clk_oe,
    output logic             main_clk_out,
    output logic             main_clk_oe,
    // Oscillator control.
    output logic             osc_run,
    output logic [31:0]      osc_freq_khz
);
    import dsc_pkg::*;

    dsc_mux_type      mux_ff;
    dsc_freq_type     frq_ff;
    logic             wr_pend_ff;
    logic             rd_pend_ff;
    logic [5:0]       idx_ff;
    logic [31:0]      hrdata_ff;
    logic [31:0]      rd_mux;
    logic [5:0]       a_idx;
    logic             take;
    logic             pdown;
    logic             mtick;
    dsc_ref_mode_type ref_mode;
    logic             ref_want;
    logic             ref_div_sel;
    logic             main_want;
    logic [3:0]       pratio [2];
    logic [3:0]       pcnt_ff [2];
    logic [3:0]       plim_ff [2];
    logic             ptick [2];
    logic [10:0]      dcnt_ff;
    logic [10:0]      dlim_ff;
    logic             ref_ph_ff;
    logic             ref_oe_ff;
    logic             main_ph_ff;
    logic             main_oe_ff;
    logic             ref_step;
    logic             main_step;
    logic [31:0]      freq_ff;

    // Bus slave: writes complete with no wait, reads take one wait state so a read that
    // follows a write to the same register sees the new value.
    assign a_idx     = haddr[7:2];
    assign take      = hsel & hready & htrans[1];
    assign hreadyout = ~rd_pend_ff;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
            idx_ff     <= 6'h00;
        end else if (ce) begin
            rd_pend_ff <= take & ~hwrite;
            if (hready) begin
                wr_pend_ff <= take & hwrite;
                idx_ff     <= a_idx;
            end else if (rd_pend_ff) begin
                wr_pend_ff <= 1'b0;
            end
        end
    end

    always_comb begin
        rd_mux = `DSC_ZERO32;
        unique case (idx_ff)
            `DSC_IDX_MUX:    rd_mux[`DSC_MUX_HI:`DSC_MUX_LO] = mux_ff;
            `DSC_IDX_DAC:    rd_mux[`DSC_DAC_HI:`DSC_DAC_LO] = frq_ff.dac;
            `DSC_IDX_OFFSET: rd_mux[`DSC_OFS_HI:0] = frq_ff.offset;
            `DSC_IDX_DIV:    rd_mux[`DSC_DIV_HI:0] = frq_ff.div;
            `DSC_IDX_STATUS: rd_mux[2:0] = {pdown, main_oe_ff, ref_oe_ff};
            `DSC_IDX_FREQ:   rd_mux = freq_ff;
            default:         rd_mux = `DSC_ZERO32;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= `DSC_ZERO32;
        end else if (ce && rd_pend_ff) begin
            hrdata_ff <= rd_mux;
        end
    end

    // Settings start from their stored defaults and may be rewritten while running.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mux_ff     <= dsc_mux_type'(MUX_RST);
            frq_ff.dac <= DAC_RST;
            frq_ff.offset <= OFS_RST;
            frq_ff.div <= DIV_RST;
        end else if (ce && wr_pend_ff) begin
            unique case (idx_ff)
                `DSC_IDX_MUX:    mux_ff <= dsc_mux_type'(hwdata[`DSC_MUX_HI:`DSC_MUX_LO]);
                `DSC_IDX_DAC:    frq_ff.dac <= hwdata[`DSC_DAC_HI:`DSC_DAC_LO];
                `DSC_IDX_OFFSET: frq_ff.offset <= hwdata[`DSC_OFS_HI:0];
                `DSC_IDX_DIV:    frq_ff.div <= hwdata[`DSC_DIV_HI:0];
                default:         ;
            endcase
        end
    end

    // Oscillator setting; the offset counts in bands away from the default band.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            freq_ff <= `DSC_ZERO32;
        end else if (ce) begin
            freq_ff <= BASE_KHZ + STEP_KHZ * {22'h000000, frq_ff.dac}
                     + OFSZ_KHZ * {27'h0000000, frq_ff.offset}
                     - OFSZ_KHZ * {27'h0000000, OFS_RST};
        end
    end
    assign osc_freq_khz = freq_ff;

    // Pin roles.
    always_comb begin
        ref_mode = dsc_ref_mode_type'({mux_ff.ref_enable_bit, mux_ff.ref_select_bit});
        if (mux_ff.ref_powerdown_bit) begin
            ref_mode = DSC_REF_PDOWN;
        end else if (mux_ff.ref_enable_bit) begin
            ref_mode = DSC_REF_OE;
        end
        ref_div_sel = mux_ff.ref_select_bit;
        ref_want    = ~ref_ctrl_pin;
        unique case (ref_mode)
            DSC_REF_SHUT: ref_want = 1'b0;
            DSC_REF_MUX: begin
                ref_want    = 1'b1;
                ref_div_sel = ref_ctrl_pin;
            end
            DSC_REF_OE:    ref_want = ~ref_ctrl_pin;
            DSC_REF_PDOWN: ref_want = ~ref_ctrl_pin;
        endcase
    end

    assign main_want = ~main_ctrl_pin;
    assign pdown = (mux_ff.ref_powerdown_bit & ref_ctrl_pin)
                 | (mux_ff.main_powerdown_bit & main_ctrl_pin)
                 | (ref_mode == DSC_REF_SHUT & ref_ctrl_pin);
    assign osc_run = ~pdown;
    assign mtick   = ce & ~pdown;

    // Prescaler ratios; the reference mux bypass acts as a ratio of one.
    assign pratio[0] = ref_div_sel ? 4'h1 << {mux_ff.ref_ratio_hi, mux_ff.ref_ratio_lo}
                                   : 4'h1;
    assign pratio[1] = 4'h1 << {mux_ff.main_ratio_hi, mux_ff.main_ratio_lo};

    // Ratios are taken at a count boundary so a change never cuts a period short.
    for (genvar i = 0; i < 2; i++) begin : g_pre
        assign ptick[i] = mtick & (pcnt_ff[i] == plim_ff[i] - 4'h1);
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                pcnt_ff[i] <= 4'h0;
                plim_ff[i] <= 4'h1;
            end else if (mtick) begin
                if (ptick[i] || (i == 0 ? !ref_oe_ff : !main_oe_ff)) begin
                    pcnt_ff[i] <= 4'h0;
                    plim_ff[i] <= pratio[i];
                end else begin
                    pcnt_ff[i] <= pcnt_ff[i] + 4'h1;
                end
            end
        end
    end

    // Programmable divider behind the main prescaler.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dcnt_ff <= 11'h000;
            dlim_ff <= `DSC_DIV_BIAS;
        end else if (mtick) begin
            if (!main_oe_ff || (ptick[1] && dcnt_ff == dlim_ff - 11'h001)) begin
                dcnt_ff <= 11'h000;
                dlim_ff <= {1'b0, frq_ff.div} + `DSC_DIV_BIAS;
            end else if (ptick[1]) begin
                dcnt_ff <= dcnt_ff + 11'h001;
            end
        end
    end

    assign ref_step  = ptick[0];
    assign main_step = mux_ff.divider_bypass_bit ? ptick[1]
                     : ptick[1] & (dcnt_ff == dlim_ff - 11'h001);

    // Output stages: an enable is taken only while the output is low, and a disabled
    // stage holds its counters at zero so the first edge always comes a fixed time later.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_ph_ff <= 1'b0;
            ref_oe_ff <= 1'b0;
        end else if (mtick) begin
            if (!ref_ph_ff) begin
                ref_oe_ff <= ref_want;
            end
            if (ref_oe_ff && ref_step && (ref_want || ref_ph_ff)) begin
                ref_ph_ff <= ~ref_ph_ff;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            main_ph_ff <= 1'b0;
            main_oe_ff <= 1'b0;
        end else if (mtick) begin
            if (!main_ph_ff) begin
                main_oe_ff <= main_want;
            end
            if (main_oe_ff && main_step && (main_want || main_ph_ff)) begin
                main_ph_ff <= ~main_ph_ff;
            end
        end
    end

    assign ref_clk_out  = ref_ph_ff;
    // A stopped oscillator may freeze a stage in its high half, so power-down releases
    // both pins at once instead of waiting for a low half that never comes.
    assign ref_clk_oe   = ref_oe_ff & ~pdown;
    assign main_clk_out = main_ph_ff;
    assign main_clk_oe  = main_oe_ff & ~pdown;

    // Checks.
    sequence s_mux_wr;
        ce && wr_pend_ff && idx_ff == `DSC_IDX_MUX;
    endsequence
    property p_mux_wr;
        @(posedge hclk) disable iff (!hresetn)
        s_mux_wr |=> mux_ff == $past(hwdata[`DSC_MUX_HI:`DSC_MUX_LO]);
    endproperty
    a_mux_wr: assert property (p_mux_wr) else $error("mux word not written");

    property p_ref_rise;
        @(posedge hclk) disable iff (!hresetn)
        $rose(ref_oe_ff) |-> !ref_clk_out;
    endproperty
    a_ref_rise: assert property (p_ref_rise) else $error("ref enable glitch");

    property p_main_fall;
        @(posedge hclk) disable iff (!hresetn)
        $fell(main_oe_ff) |-> !main_clk_out;
    endproperty
    a_main_fall: assert property (p_main_fall) else $error("main disable glitch");

    property p_bypass;
        @(posedge hclk) disable iff (!hresetn)
        mux_ff.divider_bypass_bit && main_oe_ff && main_want && ptick[1]
        |=> main_clk_out != $past(main_clk_out);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass not followed");

    property p_div_wrap;
        @(posedge hclk) disable iff (!hresetn)
        mtick && main_oe_ff && ptick[1] && dcnt_ff == dlim_ff - 11'h001 |=> dcnt_ff == 11'h000;
    endproperty
    a_div_wrap: assert property (p_div_wrap) else $error("divider wrap");

    property p_pre_range;
        @(posedge hclk) disable iff (!hresetn)
        pcnt_ff[0] < 4'h8 && pcnt_ff[1] < 4'h8 && dlim_ff >= 11'd2;
    endproperty
    a_pre_range: assert property (p_pre_range) else $error("count out of range");

    property p_pdown;
        @(posedge hclk) disable iff (!hresetn)
        pdown |=> $stable(ref_clk_out) && $stable(main_clk_out);
    endproperty
    a_pdown: assert property (p_pdown) else $error("clock ran in power-down");

    property p_shut;
        @(posedge hclk) disable iff (!hresetn)
        mux_ff[8:5] == 4'h0 && ref_ctrl_pin |-> !osc_run;
    endproperty
    a_shut: assert property (p_shut) else $error("shutdown decode");

    property p_sync;
        @(posedge hclk) disable iff (!hresetn)
        $changed(ref_clk_out) || $changed(main_clk_out) |-> $past(mtick);
    endproperty
    a_sync: assert property (p_sync) else $error("edge off master tick");
endmodule // dsc_ctrl

`default_nettype wire

// *** dsc_map.svh ***
// Register offsets, field positions and reset values of the clock synthesizer control.
// Assumes inclusion by bare name from the package and the design file.
`ifndef DSC_MAP_SVH
`define DSC_MAP_SVH

// Register indices; the byte address is four times the index.
`define DSC_IDX_DIV      6'h01
`define DSC_IDX_MUX      6'h02
`define DSC_IDX_DAC      6'h08
`define DSC_IDX_OFFSET   6'h0E
`define DSC_IDX_STATUS   6'h0F
`define DSC_IDX_FREQ     6'h10

// Field positions.
`define DSC_MUX_HI       14
`define DSC_MUX_LO       6
`define DSC_DAC_HI       15
`define DSC_DAC_LO       6
`define DSC_OFS_HI       4
`define DSC_DIV_HI       9

// Power-up defaults of the nonvolatile settings.
`define DSC_MUX_RST      9'h018
`define DSC_DAC_RST      10'd500
`define DSC_OFS_RST      5'h10
`define DSC_DIV_RST      10'h000

// The divider ratio is the stored value plus this.
`define DSC_DIV_BIAS     11'd2
`define DSC_ZERO32       32'h0000_0000

`endif

// *** dsc_pkg.sv ***
// Types shared by the clock synthesizer control.
// Assumes dsc_map.svh is on the include path.
`default_nettype none

package dsc_pkg;
    `include "dsc_map.svh"

    typedef struct packed {
        logic main_powerdown_bit;
        logic ref_powerdown_bit;
        logic ref_select_bit;
        logic ref_enable_bit;
        logic ref_ratio_hi;
        logic ref_ratio_lo;
        logic main_ratio_hi;
        logic main_ratio_lo;
        logic divider_bypass_bit;
    } dsc_mux_type;

    typedef struct packed {
        logic [9:0] dac;
        logic [4:0] offset;
        logic [9:0] div;
    } dsc_freq_type;

    typedef enum logic [1:0] {
        DSC_REF_SHUT  = 2'b00,
        DSC_REF_MUX   = 2'b01,
        DSC_REF_OE    = 2'b10,
        DSC_REF_PDOWN = 2'b11
    } dsc_ref_mode_type;
endpackage

`default_nettype wire

// *** dsc_host.sv ***
// AHB-Lite master that stands in for the host programming the synthesizer.
// Assumes its hready input is the single slave's hreadyout.
`default_nettype none

module dsc_host (
    // Clock.
    input  wire logic        hclk,
    // Slave answer.
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    // Master request.
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        hsel   = 1'h0;
        haddr  = 32'h0;
        htrans = 2'h0;
        hwrite = 1'h0;
        hsize  = 3'h2;
        hwdata = 32'h0;
    end

    // One single word transfer; read data is taken at the edge that ends the data phase.
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge hclk);
        hsel   <= 1'h1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hready !== 1'h1);
        hsel   <= 1'h0;
        htrans <= 2'h0;
        // A read phase carries the inverse so a stale write word never looks valid.
        hwdata <= wr ? d : ~d;
        do @(posedge hclk); while (hready !== 1'h1);
        q = hrdata;
    endtask
endmodule // dsc_host

`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the synthesizer output-path control.
// Assumes dsc_pkg and dsc_host are compiled first; hclk stands for the master clock.
`default_nettype none

module tb;
    import dsc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic        hclk = 1'h0;
    logic        hresetn = 1'h0;
    logic        ref_pin = 1'h0;
    logic        main_pin = 1'h0;
    logic        ce = 1'h1;
    logic        v;
    logic        hsel, hwrite, hready, hresp;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, q, osc_freq_khz;
    logic        ref_clk_out, ref_clk_oe, main_clk_out, main_clk_oe, osc_run;
    logic [9:0]  dac;
    logic [4:0]  ofs;
    int          fail_count = 0;
    int          n_tests = 0;
    int          c, n, p, t1, t2;

    always #5 hclk = ~hclk;

    dsc_host u_host (.hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    dsc_ctrl #(.STEP_KHZ(32'h0000_000A), .OFSZ_KHZ(32'h0000_1400), .BASE_KHZ(32'h0001_67C4))
    u_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .ref_ctrl_pin(ref_pin),
        .main_ctrl_pin(main_pin), .ref_clk_out(ref_clk_out), .ref_clk_oe(ref_clk_oe),
        .main_clk_out(main_clk_out), .main_clk_oe(main_clk_oe), .osc_run(osc_run),
        .osc_freq_khz(osc_freq_khz));

    function automatic logic [31:0] exp_freq(input logic [9:0] d, input logic [4:0] o);
        return 32'(92100 + int'(d) * 10 + (int'(o) - 16) * 5120);
    endfunction

    function automatic logic [31:0] mux(input logic pd1, pd0, sel, en,
                                        input logic [1:0] rm, mm, input logic byp);
        dsc_mux_type m;
        m = '{pd1, pd0, sel, en, rm[1], rm[0], mm[1], mm[0], byp};
        return {17'h0, m, 6'h0};
    endfunction

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        u_host.xfer(1'h1, a, d, q);
    endtask

    task automatic rd(input logic [31:0] a);
        u_host.xfer(1'h0, a, 32'h0, q);
    endtask

    task automatic setp(input logic r, input logic m);
        @(posedge hclk);
        ref_pin  <= r;
        main_pin <= m;
        repeat (300) @(posedge hclk);
        #1;
    endtask

    // Cycles between two rising edges; the first rise only marks the start.
    task automatic per(input logic mn, output int pd);
        int t, r1;
        logic pv, cv;
        r1 = -1;
        pd = -1;
        pv = 1'h1;
        for (t = 0; t < 6000 && pd < 0; t++) begin
            @(posedge hclk);
            #1;
            cv = mn ? main_clk_out : ref_clk_out;
            if (cv === 1'h1 && pv === 1'h0) begin
                if (r1 < 0) r1 = t;
                else pd = t - r1;
            end
            pv = cv;
        end
    endtask

    task automatic dly(output int t);
        setp(1'h1, 1'h0);
        repeat ($urandom_range(7)) @(posedge hclk);
        @(posedge hclk);
        ref_pin <= 1'h0;
        t = 0;
        do begin
            @(posedge hclk);
            #1;
            t++;
        end while (ref_clk_out !== 1'h1 && t < 200);
        chk("oe_at_first_edge", 32'h1, 32'(ref_clk_oe));
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    initial begin
        repeat (80000) @(posedge hclk);
        fail_count++;
        print_verdict();
    end

    initial begin
        void'($urandom(32'hE757E851));
        repeat (16) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        #1;
        chk("freq_default", exp_freq(10'd500, 5'h10), osc_freq_khz);
        chk("hresp", 32'h0, 32'(hresp));
        rd(32'h08); chk("mux_default", 32'h0000_0600, q);
        rd(32'h20); chk("dac_default", 32'h0000_7D00, q);
        rd(32'h38); chk("offset_default", 32'h0000_0010, q);
        rd(32'h04); chk("div_default", 32'h0, q);
        wr(32'h7C, 32'hFFFF_FFFF);
        rd(32'h7C); chk("unmapped", 32'h0, q);
        for (c = 0; c < 4; c++) begin
            dac = 10'($urandom);
            ofs = 5'h0A + 5'($urandom_range(12));
            wr(32'h20, {16'h0, dac, 6'h0});
            wr(32'h38, {27'h0, ofs});
            rd(32'h20); chk("dac_readback", {16'h0, dac, 6'h0}, q);
            rd(32'h40); chk("freq_reg", exp_freq(dac, ofs), q);
            chk("osc_freq", exp_freq(dac, ofs), osc_freq_khz);
        end
        setp(1'h0, 1'h0);
        for (c = 0; c < 4; c++) begin
            wr(32'h08, mux(1'h0, 1'h0, 1'h1, 1'h1, c[1:0], 2'h0, 1'h0));
            setp(1'h0, 1'h0);
            per(1'h0, p); chk("ref_period", 32'(2 << c), 32'(p));
        end
        for (c = 0; c < 4; c++) begin
            n = (c == 0) ? 1023 : $urandom_range(5);
            wr(32'h04, 32'(n));
            wr(32'h08, mux(1'h0, 1'h0, 1'h1, 1'h1, 2'h3, c[1:0], 1'h0));
            setp(1'h0, 1'h0);
            per(1'h1, p); chk("main_div", 32'((2 << c) * (n + 2)), 32'(p));
            per(1'h0, p); chk("ref_indep", 32'h10, 32'(p));
            wr(32'h08, mux(1'h0, 1'h0, 1'h1, 1'h1, 2'h3, c[1:0], 1'h1));
            setp(1'h0, 1'h0);
            per(1'h1, p); chk("main_bypass", 32'(2 << c), 32'(p));
        end
        wr(32'h08, mux(1'h0, 1'h0, 1'h0, 1'h0, 2'h1, 2'h0, 1'h0));
        setp(1'h1, 1'h0);
        chk("shut_run", 32'h0, 32'(osc_run));
        chk("shut_oe", 32'h0, 32'(ref_clk_oe));
        setp(1'h0, 1'h0);
        chk("shut_run_lo", 32'h1, 32'(osc_run));
        chk("shut_oe_lo", 32'h0, 32'(ref_clk_oe));
        wr(32'h08, mux(1'h0, 1'h0, 1'h1, 1'h0, 2'h1, 2'h0, 1'h0));
        setp(1'h1, 1'h0);
        per(1'h0, p); chk("sel_hi", 32'h4, 32'(p));
        setp(1'h0, 1'h0);
        per(1'h0, p); chk("sel_lo", 32'h2, 32'(p));
        wr(32'h08, mux(1'h0, 1'h1, 1'h0, 1'h0, 2'h1, 2'h0, 1'h0));
        setp(1'h1, 1'h0);
        chk("pd0_run", 32'h0, 32'(osc_run));
        chk("pd0_oe", 32'h0, 32'(ref_clk_oe));
        setp(1'h0, 1'h0);
        per(1'h0, p); chk("pd0_undiv", 32'h2, 32'(p));
        wr(32'h08, mux(1'h0, 1'h0, 1'h1, 1'h1, 2'h1, 2'h0, 1'h0));
        setp(1'h1, 1'h1);
        chk("en_oe", 32'h0, 32'(ref_clk_oe));
        chk("main_oe_hi", 32'h0, 32'(main_clk_oe));
        chk("en_run", 32'h1, 32'(osc_run));
        rd(32'h3C); chk("status_off", 32'h0, q);
        wr(32'h08, mux(1'h1, 1'h0, 1'h1, 1'h1, 2'h1, 2'h0, 1'h0));
        setp(1'h0, 1'h1);
        chk("pd1_run", 32'h0, 32'(osc_run));
        setp(1'h0, 1'h0);
        chk("main_oe_lo", 32'h1, 32'(main_clk_oe));
        wr(32'h08, mux(1'h0, 1'h0, 1'h1, 1'h1, 2'h2, 2'h0, 1'h0));
        dly(t1);
        dly(t2);
        chk("enable_delay", 32'(t1), 32'(t2));
        @(posedge hclk);
        ce <= 1'h0;
        @(posedge hclk);
        #1;
        v = ref_clk_out;
        repeat (20) @(posedge hclk);
        #1;
        chk("ce_freeze", 32'(v), 32'(ref_clk_out));
        @(posedge hclk);
        ce <= 1'h1;
        per(1'h0, p); chk("ce_resume", 32'h8, 32'(p));
        print_verdict();
    end
endmodule // tb

`default_nettype wire
